// ===== logic/lin_channel.sv
`timescale 1ns/1ps
`default_nettype none
module lin_channel
   import lin_mode_pkg::*;
#(
   parameter int TXTO_CYC = TXTO_CYC_DEF
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Channel link.
   lin_chan_if.chan ch
);
   typedef struct packed {
      logic [CNT_W-1:0] en_cnt;
      logic gate;
      logic [CNT_W-1:0] to_cnt;
      logic timed_out;
      logic [3:0] filt_cnt;
      logic rx_filt;
      logic [CNT_W-1:0] wk_cnt;
      logic wk_long;
      logic woken;
      logic drive;
      logic fail_ev;
      logic wake_ev;
   } chan_state_t;
   chan_state_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.fail_ev = 1'b0;
      s_d.wake_ev = 1'b0;
      // Noise filter on the received level.
      if (ch.bus_s == s_q.rx_filt) begin
         s_d.filt_cnt = '0;
      end else if (s_q.filt_cnt == 4'(FILT_CYC - 1)) begin
         s_d.rx_filt = ch.bus_s;
         s_d.filt_cnt = '0;
      end else begin
         s_d.filt_cnt = s_q.filt_cnt + 4'h1;
      end
      // Enabling interval restarts on entry into normal mode.
      if (ch.mode_chg) begin
         s_d.en_cnt = '0;
         s_d.gate = 1'b1;
         s_d.woken = 1'b0;
         s_d.wk_cnt = '0;
         s_d.wk_long = 1'b0;
      end else if (s_q.gate) begin
         if (s_q.en_cnt >= CNT_W'(EN_CYC - 1)) begin
            if (ch.txd_s) begin
               s_d.gate = 1'b0;
            end
         end else begin
            s_d.en_cnt = s_q.en_cnt + 1'b1;
         end
      end
      // Transmit timeout.
      if (ch.txd_s) begin
         s_d.to_cnt = '0;
         s_d.timed_out = 1'b0;
      end else if (ch.mode == MODE_NORMAL && !s_q.gate && !s_q.timed_out) begin
         if (s_q.to_cnt >= CNT_W'(TXTO_CYC - 1)) begin
            s_d.timed_out = 1'b1;
            s_d.fail_ev = 1'b1;
         end else begin
            s_d.to_cnt = s_q.to_cnt + 1'b1;
         end
      end
      // Driver: dominant only while input low and enabled.
      s_d.drive = (ch.mode == MODE_NORMAL) && ch.chip_stop_like && !s_d.gate
         && !s_d.timed_out && !ch.txd_s;
      // Wake detection only in wake-capable mode.
      if (ch.mode != MODE_WAKE) begin
         s_d.wk_cnt = '0;
         s_d.wk_long = 1'b0;
         // Leaving wake-capable mode rearms wake detection.
         s_d.woken = 1'b0;
      end else if (!s_q.woken) begin
         if (!s_q.rx_filt) begin
            if (s_q.wk_cnt >= CNT_W'(WK_CYC - 1)) begin
               s_d.wk_long = 1'b1;
            end else begin
               s_d.wk_cnt = s_q.wk_cnt + 1'b1;
            end
         end else begin
            if (s_q.wk_long) begin
               s_d.woken = 1'b1;
               s_d.wake_ev = 1'b1;
            end
            s_d.wk_cnt = '0;
            s_d.wk_long = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{rx_filt: 1'b1, gate: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign ch.drive = s_q.drive;
   assign ch.fail_ev = s_q.fail_ev;
   assign ch.wake_ev = s_q.wake_ev;
   // Receive output: filtered bus in receive-only and normal, in wake mode high until a wake then low, high when off.
   assign ch.rxd = (ch.mode == MODE_OFF) ? 1'b1 :
      (ch.mode == MODE_WAKE) ? !s_q.woken : s_q.rx_filt;
endmodule
`default_nettype wire

// ===== logic/lin_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lin_mode_ctrl
   import lin_mode_pkg::*;
#(
   parameter int TXTO_CYC = TXTO_CYC_DEF
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Microcontroller side pins.
   input wire logic [1:0] lin_transmit_input,
   output logic [1:0] lin_receive_output,
   // Bus side.
   input wire logic [1:0] bus_level_in,
   output logic [1:0] bus_dominant_drive,
   // Interrupt.
   output logic irq
);
   typedef struct packed {
      logic [1:0] channel_one_mode_field;
      logic [1:0] channel_two_mode_field;
      logic [2:0] chip_mode;
      logic [1:0] channel_one_failure_flag;
      logic [1:0] channel_two_failure_flag;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_en;
      logic [1:0] txd_m;
      logic [1:0] txd_s;
      logic [1:0] bus_m;
      logic [1:0] bus_s;
      logic [1:0] mode_chg;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [1:0] rxd;
      logic [1:0] drive;
      logic irq;
   } ctrl_state_t;
   ctrl_state_t s_q, s_d;

   lin_chan_if cif [2] ();

   function automatic logic mode_allowed(input logic [1:0] m, input logic [2:0] c);
      logic ns;
      ns = (c == CHIP_NORMAL) || (c == CHIP_STOP);
      unique case (m)
         MODE_OFF: mode_allowed = 1'b1;
         MODE_WAKE: mode_allowed = (c != CHIP_INIT);
         MODE_RXONLY: mode_allowed = ns;
         MODE_NORMAL: mode_allowed = (c == CHIP_NORMAL);
      endcase
   endfunction

   function automatic logic [1:0] next_mode(input logic [1:0] cur, input logic [1:0] req,
         input logic [2:0] c);
      next_mode = mode_allowed(req, c) ? req : cur;
   endfunction

   logic [1:0] ev_wake, ev_fail, ch_rxd, ch_drv;
   logic wr, rd;

   assign wr = psel && penable && pwrite && !s_q.pready;
   assign rd = psel && penable && !pwrite && !s_q.pready;

   always_comb begin
      logic [1:0] m1, m2;
      m1 = s_q.channel_one_mode_field;
      m2 = s_q.channel_two_mode_field;
      s_d = s_q;
      s_d.txd_m = lin_transmit_input;
      s_d.txd_s = s_q.txd_m;
      s_d.bus_m = bus_level_in;
      s_d.bus_s = s_q.bus_m;
      s_d.pready = psel && penable && !s_q.pready;
      s_d.pslverr = 1'b0;
      s_d.mode_chg = 2'b00;
      // Chip mode outside normal/stop drops receive-only and normal modes to off.
      if (!(s_q.chip_mode == CHIP_NORMAL || s_q.chip_mode == CHIP_STOP)) begin
         if (m1[1]) begin
            m1 = MODE_OFF;
         end
         if (m2[1]) begin
            m2 = MODE_OFF;
         end
      end
      if (wr) begin
         unique case (paddr)
            ADDR_MODE: begin
               m1 = next_mode(m1, pwdata[MODE_CH1_LSB +: 2], s_q.chip_mode);
               m2 = next_mode(m2, pwdata[MODE_CH2_LSB +: 2], s_q.chip_mode);
            end
            ADDR_CHIP: s_d.chip_mode = pwdata[2:0];
            ADDR_IRQ_CLR: s_d.irq_stat = s_q.irq_stat & ~pwdata[IRQ_W-1:0];
            ADDR_IRQ_EN: s_d.irq_en = pwdata[IRQ_W-1:0];
            ADDR_STATUS: begin
               s_d.channel_one_failure_flag = s_q.channel_one_failure_flag & ~pwdata[1:0];
               s_d.channel_two_failure_flag = s_q.channel_two_failure_flag & ~pwdata[3:2];
            end
            default: s_d.pslverr = 1'b1;
         endcase
      end
      if (rd) begin
         s_d.prdata = '0;
         unique case (paddr)
            ADDR_MODE: s_d.prdata[3:0] = {s_q.channel_two_mode_field,
               s_q.channel_one_mode_field};
            ADDR_CHIP: s_d.prdata[2:0] = s_q.chip_mode;
            ADDR_STATUS: s_d.prdata[3:0] = {s_q.channel_two_failure_flag,
               s_q.channel_one_failure_flag};
            ADDR_IRQ_STAT: s_d.prdata[IRQ_W-1:0] = s_q.irq_stat;
            ADDR_IRQ_EN: s_d.prdata[IRQ_W-1:0] = s_q.irq_en;
            default: s_d.pslverr = 1'b1;
         endcase
      end
      s_d.mode_chg[0] = (m1 == MODE_NORMAL) && (m1 != s_q.channel_one_mode_field);
      s_d.mode_chg[1] = (m2 == MODE_NORMAL) && (m2 != s_q.channel_two_mode_field);
      s_d.channel_one_mode_field = m1;
      s_d.channel_two_mode_field = m2;
      // Hardware set wins over software clear.
      if (ev_fail[0]) begin
         s_d.channel_one_failure_flag[0] = 1'b1;
      end
      if (ev_fail[1]) begin
         s_d.channel_two_failure_flag[0] = 1'b1;
      end
      s_d.irq_stat = s_d.irq_stat | {ev_fail, ev_wake};
      s_d.rxd = ch_rxd;
      s_d.drive = ch_drv;
      s_d.irq = |(s_d.irq_stat & s_d.irq_en);
   end

   for (genvar i = 0; i < 2; i++) begin : g_ch
      assign cif[i].mode = (i == 0) ? s_q.channel_one_mode_field : s_q.channel_two_mode_field;
      assign cif[i].chip_stop_like = (s_q.chip_mode == CHIP_NORMAL) ||
         (s_q.chip_mode == CHIP_STOP);
      assign cif[i].mode_chg = s_q.mode_chg[i];
      assign cif[i].txd_s = s_q.txd_s[i];
      assign cif[i].bus_s = s_q.bus_s[i];
      assign ev_wake[i] = cif[i].wake_ev;
      assign ev_fail[i] = cif[i].fail_ev;
      assign ch_rxd[i] = cif[i].rxd;
      assign ch_drv[i] = cif[i].drive;
      lin_channel #(.TXTO_CYC(TXTO_CYC)) u_ch (
         .pclk(pclk),
         .presetn(presetn),
         .ch(cif[i])
      );
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{chip_mode: CHIP_NORMAL, txd_m: 2'h3, txd_s: 2'h3, bus_m: 2'h3,
            bus_s: 2'h3, rxd: 2'h3, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign lin_receive_output = s_q.rxd;
   assign bus_dominant_drive = s_q.drive;
   assign irq = s_q.irq;
endmodule
`default_nettype wire

// ===== pkg/lin_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lin_chan_if;
   logic [1:0] mode;
   logic chip_stop_like;
   logic mode_chg;
   logic txd_s;
   logic bus_s;
   logic drive;
   logic rxd;
   logic fail_ev;
   logic wake_ev;
   modport chan (input mode, chip_stop_like, mode_chg, txd_s, bus_s,
      output drive, rxd, fail_ev, wake_ev);
   modport ctrl (output mode, chip_stop_like, mode_chg, txd_s, bus_s,
      input drive, rxd, fail_ev, wake_ev);
endinterface
`default_nettype wire

// ===== pkg/lin_mode_pkg.sv
`default_nettype none
package lin_mode_pkg;
   // Transceiver mode field encodings.
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_WAKE = 2'h1;
   localparam logic [1:0] MODE_RXONLY = 2'h2;
   localparam logic [1:0] MODE_NORMAL = 2'h3;
   // Chip operating modes.
   localparam logic [2:0] CHIP_INIT = 3'h0;
   localparam logic [2:0] CHIP_NORMAL = 3'h1;
   localparam logic [2:0] CHIP_STOP = 3'h2;
   localparam logic [2:0] CHIP_SLEEP = 3'h3;
   localparam logic [2:0] CHIP_RESTART = 3'h4;
   localparam logic [2:0] CHIP_FAILSAFE = 3'h5;
   // Register byte offsets.
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_CHIP = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
   // Field positions in the mode register.
   localparam int MODE_CH1_LSB = 0;
   localparam int MODE_CH2_LSB = 2;
   // Interrupt bits: [0] ch1 wake, [1] ch2 wake, [2] ch1 fail, [3] ch2 fail.
   localparam int IRQ_W = 4;
   // Timing.
   localparam int CLK_MHZ = 50;
   localparam int T_EN_US = 10;
   localparam int EN_CYC = T_EN_US * CLK_MHZ;
   localparam int T_TXTO_MS = 12;
   localparam int TXTO_CYC_DEF = T_TXTO_MS * 1000 * CLK_MHZ;
   localparam int T_WK_US = 50;
   localparam int WK_CYC = T_WK_US * CLK_MHZ;
   localparam int T_FILT_NS = 200;
   localparam int FILT_CYC = (T_FILT_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 20;
endpackage
`default_nettype wire

// ===== tb/lin_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module lin_mcu_model (
   // Clock.
   input wire logic pclk,
   // Bench request for a dominant level per channel.
   input wire logic [1:0] send_dom,
   // Transmit pins.
   output logic [1:0] tx
);
   // Recessive unless a dominant bit is asked for, so an early low can be released.
   always_ff @(posedge pclk) tx <= ~send_dom;
endmodule
`default_nettype wire

// ===== tb/lin_mode_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lin_mode_ctrl_chk
   import lin_mode_pkg::*;
#(
   parameter int TXTO_CYC = TXTO_CYC_DEF
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins.
   input wire logic [1:0] lin_transmit_input,
   input wire logic [1:0] lin_receive_output,
   input wire logic [1:0] bus_dominant_drive
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   int en_q;
   int dr_q;
   logic wr_norm;
   assign wr_norm = psel && penable && pready && pwrite && paddr == ADDR_MODE
      && pwdata[1:0] == MODE_NORMAL;
   // Counts the enabling interval and the length of each dominant drive on channel one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 0;
         dr_q <= 0;
      end else begin
         en_q <= wr_norm ? EN_CYC - 2 : (en_q > 0 ? en_q - 1 : 0);
         dr_q <= bus_dominant_drive[0] ? dr_q + 1 : 0;
      end
   end
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_off_at_reset: assert property ($rose(presetn) |->
      lin_receive_output == 2'h3 && bus_dominant_drive == 2'h0 && !pready)
      else $error("outputs not idle after reset");
   chk_tx_high_one: assert property (lin_transmit_input[0] [*6] |=> !bus_dominant_drive[0])
      else $error("channel one driven while input high");
   chk_tx_high_two: assert property (lin_transmit_input[1] [*6] |=> !bus_dominant_drive[1])
      else $error("channel two driven while input high");
   chk_tx_timeout: assert property (dr_q < TXTO_CYC + 4)
      else $error("driver stayed on past timeout");
   chk_enable_gate: assert property (en_q != 0 |-> !bus_dominant_drive[0])
      else $error("driver on during enabling");
endmodule
bind lin_mode_ctrl lin_mode_ctrl_chk #(.TXTO_CYC(TXTO_CYC)) lin_mode_ctrl_chk_i (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .lin_transmit_input,
   .lin_receive_output, .bus_dominant_drive);
`default_nettype wire

// ===== tb/lin_mode_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lin_mode_ctrl_tb;
   import lin_mode_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [1:0] lin_transmit_input, lin_receive_output, bus_dominant_drive, send_dom, bus_src;
   wire [1:0] bus_level_in = bus_src & ~bus_dominant_drive;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   lin_mode_ctrl #(.TXTO_CYC(50)) lin_mode_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .lin_transmit_input, .lin_receive_output,
      .bus_level_in, .bus_dominant_drive, .irq);
   lin_mcu_model lin_mcu_model_i (.pclk, .send_dom, .tx(lin_transmit_input));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic end_sim;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), r, x);
   endtask
   task automatic ms(input logic [31:0] c, input logic [31:0] m, input logic [31:0] x);
      wr(ADDR_CHIP, c);
      wr(ADDR_MODE, m);
      rd(ADDR_MODE, x);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Cuts a hung run short.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      send_dom = 2'h0;
      bus_src = 2'h3;
      wt(16);
      presetn <= 1'b1;
      rd(ADDR_MODE, 32'h0);
      chk("rxd", lin_receive_output, 32'h3);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", e, 32'h1);
      ms(CHIP_STOP, 32'h2, 32'h2);
      ms(CHIP_STOP, 32'h3, 32'h2);
      ms(CHIP_SLEEP, 32'h2, 32'h0);
      ms(CHIP_INIT, 32'h1, 32'h0);
      ms(CHIP_SLEEP, 32'h1, 32'h1);
      ms(CHIP_SLEEP, 32'h0, 32'h0);
      send_dom <= 2'h1;
      ms(CHIP_NORMAL, 32'h3, 32'h3);
      wt(300);
      chk("drive", bus_dominant_drive, 32'h0);
      wt(300);
      chk("drive", bus_dominant_drive, 32'h0);
      send_dom <= 2'h0;
      wt(10);
      send_dom <= 2'h1;
      wt(10);
      chk("drive", bus_dominant_drive, 32'h1);
      wt(70);
      chk("drive", bus_dominant_drive, 32'h0);
      rd(ADDR_IRQ_STAT, 32'h4);
      rd(ADDR_STATUS, 32'h1);
      chk("irq", irq, 32'h0);
      wr(ADDR_IRQ_EN, 32'hF);
      wt(3);
      chk("irq", irq, 32'h1);
      send_dom <= 2'h0;
      wt(10);
      send_dom <= 2'h1;
      wt(10);
      chk("drive", bus_dominant_drive, 32'h1);
      send_dom <= 2'h0;
      wt(10);
      wr(ADDR_IRQ_CLR, 32'h4);
      rd(ADDR_IRQ_STAT, 32'h0);
      wr(ADDR_STATUS, 32'h1);
      rd(ADDR_STATUS, 32'h0);
      chk("irq", irq, 32'h0);
      bus_src <= 2'h0;
      wt(30);
      chk("rxd", lin_receive_output, 32'h2);
      bus_src <= 2'h3;
      wt(30);
      bus_src <= 2'h0;
      wt(3);
      bus_src <= 2'h3;
      wt(20);
      chk("rxd", lin_receive_output, 32'h3);
      wr(ADDR_MODE, 32'h4);
      bus_src <= 2'h0;
      wt(2600);
      bus_src <= 2'h3;
      wt(40);
      chk("rxd", lin_receive_output, 32'h1);
      rd(ADDR_MODE, 32'h4);
      rd(ADDR_IRQ_STAT, 32'h2);
      chk("irq", irq, 32'h1);
      // Toggling the mode rearms wake detection and releases the receive output.
      wr(ADDR_MODE, 32'h0);
      wr(ADDR_MODE, 32'h4);
      wt(5);
      chk("rxd", lin_receive_output, 32'h3);
      // A second reset in mid-run returns both channels to off.
      presetn <= 1'b0;
      wt(2);
      presetn <= 1'b1;
      rd(ADDR_MODE, 32'h0);
      chk("rxd", lin_receive_output, 32'h3);
      rd(ADDR_IRQ_STAT, 32'h0);
      chk("drive", bus_dominant_drive, 32'h0);
      end_sim();
   end
endmodule
`default_nettype wire
